// ===== core/presence_pkg.sv
// Purpose: shared constants and types for the presence decision block
// Assumes: 100 MHz single clock
// Notes:   all offsets are byte addresses of 32-bit words
package presence_pkg;

  // ***********************************************************
  // clock and timing
  // ***********************************************************
  localparam int CLK_HZ      = 100_000_000;
  localparam int BAUD_RATE   = 256_000;
  localparam int BAUD_DIV    = CLK_HZ / BAUD_RATE;
  localparam int HOLD_UNIT_S = 1;
  localparam int SEC_CYCLES  = CLK_HZ * HOLD_UNIT_S;
  localparam int UART_BITS   = 10;

  // ***********************************************************
  // gates and energies
  // ***********************************************************
  localparam int          GATE_CNT     = 9;
  localparam int          GATE_W       = 4;
  localparam int          ENERGY_W     = 8;
  localparam logic [15:0] GATE_CM      = 16'h004b;
  localparam logic [3:0]  MAX_GATE_MIN = 4'h1;
  localparam logic [3:0]  MAX_GATE_MAX = 4'h8;
  localparam logic [7:0]  THR_MAX      = 8'h64;
  localparam int          PW_BYTES     = 6;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam int         ADDR_W         = 8;
  localparam int         DATA_W         = 32;
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_MAX_MOVE  = 8'h08;
  localparam logic [7:0] ADDR_MAX_STILL = 8'h0c;
  localparam logic [7:0] ADDR_HOLD      = 8'h10;
  localparam logic [7:0] ADDR_PW_LO     = 8'h14;
  localparam logic [7:0] ADDR_PW_HI     = 8'h18;
  localparam logic [7:0] ADDR_THR_MOVE  = 8'h40;
  localparam logic [7:0] ADDR_THR_STILL = 8'h80;
  localparam int         CTRL_REPORT    = 0;
  localparam int         CTRL_FACTORY   = 1;

  // ***********************************************************
  // factory defaults (password value arbitrary)
  // ***********************************************************
  localparam logic [3:0]  DEF_MAX_GATE = 4'h8;
  localparam logic [7:0]  DEF_THR      = 8'h28;
  localparam logic [15:0] DEF_HOLD     = 16'h0005;
  localparam logic [47:0] DEF_PW       = 48'h313233343536;

  // ***********************************************************
  // report frame
  // ***********************************************************
  localparam logic [7:0] REP_HEAD = 8'haa;
  localparam logic [7:0] REP_TAIL = 8'h55;
  localparam logic [3:0] REP_LAST = 4'h8;
  localparam int         FIFO_DEPTH = 16;

  typedef enum logic [0:0] {REP_IDLE, REP_SEND} rep_state_t;

endpackage : presence_pkg

// ===== core/byte_stream_if.sv
// Purpose: valid/ready byte stream between internal modules
// Assumes: single clock domain
// Notes:   a word moves when valid and ready are both high
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// ===== core/report_fifo.sv
// Purpose: report byte buffer between sequencer and serial sender
// Assumes: depth is a power of two
// Notes:   full shows as wr.ready low; sequencer stalls on it
`timescale 1ns/1ps
module report_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic    clk,
  input wire logic    rst,
  byte_stream_if.snk  wr,
  byte_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic             full;
  logic             empty;

  assign empty    = (wptr == rptr);
  assign full     = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rptr[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (wr.valid && !full)
    begin
      mem[wptr[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (wr.valid && !full)
      begin
        wptr <= wptr + 1'b1;
      end
      if (rd.ready && !empty)
      begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule : report_fifo

// ===== core/serial_sender.sv
// Purpose: 8 data bits, no parity, one stop bit serial transmitter
// Assumes: DIV clock cycles per bit
// Notes:   line idles high; takes a byte only when idle
`timescale 1ns/1ps
module serial_sender
  import presence_pkg::*;
#(
  parameter int DIV = presence_pkg::BAUD_DIV
) (
  input wire logic    clk,
  input wire logic    rst,
  byte_stream_if.snk  in,
  output logic        tx
);
  logic [UART_BITS-1:0] shift;
  logic [3:0]           bits_left;
  logic [15:0]          baud_cnt;

  assign in.ready = (bits_left == 4'h0);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shift     <= '1;
      bits_left <= 4'h0;
      baud_cnt  <= 16'h0000;
      tx        <= 1'b1;
    end
    else if (bits_left == 4'h0)
    begin
      tx <= 1'b1;
      if (in.valid)
      begin
        // stop, data lsb first, start
        shift     <= {1'b1, in.data, 1'b0};
        bits_left <= 4'(UART_BITS);
        baud_cnt  <= 16'h0000;
      end
    end
    else if (baud_cnt == 16'h0000)
    begin
      tx        <= shift[0];
      shift     <= {1'b1, shift[UART_BITS-1:1]};
      baud_cnt  <= 16'(DIV - 1);
    end
    else
    begin
      baud_cnt <= baud_cnt - 16'h0001;
      if (baud_cnt == 16'h0001)
      begin
        bits_left <= bits_left - 4'h1;
      end
    end
  end
endmodule : serial_sender

// ===== core/presence_decision.sv
// Purpose: presence decision, hold timer, output pin and serial report
// Assumes: per-gate energies arrive in gate order, then a frame_end pulse
// Notes:   configuration store has no reset; load defaults once after power-up
`timescale 1ns/1ps

// Overview of operation
// - output pin high while presence held
// - serial runs 256000 baud, 8N1
// - each frame not ending mid-report sends state, distances, energies
// - settings kept in store reset cannot clear
// - range counted in gates of 0.75m
// - separate move and still limits 1..8
// - targets past limit gate are ignored
// - present only when energy exceeds threshold
// - per-gate thresholds programmable 0..100
// - threshold 100 passes only energies above 100
// - hold timer restarts on detection, then clears
// - settings locked while reporting runs
// - six byte access password stored
module presence_decision
  import presence_pkg::*;
#(
  parameter int SEC_DIV = presence_pkg::SEC_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic [presence_pkg::ADDR_W-1:0]   addr,
  input  wire logic [presence_pkg::DATA_W-1:0]   wdata,
  input  wire logic                              wr,
  input  wire logic                              rd,
  output logic      [presence_pkg::DATA_W-1:0]   rdata,
  input  wire logic                              sample_valid,
  input  wire logic [presence_pkg::GATE_W-1:0]   sample_gate,
  input  wire logic [presence_pkg::ENERGY_W-1:0] move_energy,
  input  wire logic [presence_pkg::ENERGY_W-1:0] still_energy,
  input  wire logic                              frame_end,
  output logic                                   presence_out,
  output logic                                   serial_tx
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic                report_en;
    logic                refused;
    logic                scan_move_hit;
    logic [GATE_W-1:0]   scan_move_gate;
    logic [ENERGY_W-1:0] scan_move_e;
    logic                scan_still_hit;
    logic [GATE_W-1:0]   scan_still_gate;
    logic [ENERGY_W-1:0] scan_still_e;
    logic                raw_move;
    logic                raw_still;
    logic [GATE_W-1:0]   rep_move_gate;
    logic [ENERGY_W-1:0] rep_move_e;
    logic [GATE_W-1:0]   rep_still_gate;
    logic [ENERGY_W-1:0] rep_still_e;
    logic                presence;
    logic [15:0]         hold_cnt;
    logic [31:0]         sec_cnt;
    rep_state_t          rep_state;
    logic [3:0]          rep_idx;
    logic [DATA_W-1:0]   rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // ***********************************************************
  // retained settings
  // ***********************************************************
  // no reset on purpose: a block reset must not lose settings
  logic [ENERGY_W-1:0] thr_move  [GATE_CNT];
  logic [ENERGY_W-1:0] thr_still [GATE_CNT];
  logic [GATE_W-1:0]   max_move;
  logic [GATE_W-1:0]   max_still;
  logic [15:0]         hold_sec;
  logic [47:0]         password;

  logic cfg_sel;
  logic cfg_wr;
  logic factory_wr;
  logic sec_tick;
  logic move_det;
  logic still_det;
  logic [15:0] move_dist;
  logic [15:0] still_dist;

  byte_stream_if #(.WIDTH(8)) rep_in ();
  byte_stream_if #(.WIDTH(8)) rep_out ();

  function automatic logic is_thr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    is_thr = (a >= base) && (a < base + 8'(4 * GATE_CNT)) && (a[1:0] == 2'b00);
  endfunction : is_thr

  function automatic logic [GATE_W-1:0] thr_index(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] off;
    off       = a - base;
    thr_index = off[GATE_W+1:2];
  endfunction : thr_index

  function automatic logic [GATE_W-1:0] clamp_gate(input logic [DATA_W-1:0] v);
    if (v < 32'(MAX_GATE_MIN))
      clamp_gate = MAX_GATE_MIN;
    else if (v > 32'(MAX_GATE_MAX))
      clamp_gate = MAX_GATE_MAX;
    else
      clamp_gate = v[GATE_W-1:0];
  endfunction : clamp_gate

  function automatic logic [ENERGY_W-1:0] clamp_thr(input logic [DATA_W-1:0] v);
    clamp_thr = (v > 32'(THR_MAX)) ? THR_MAX : v[ENERGY_W-1:0];
  endfunction : clamp_thr

  function automatic logic [15:0] gate_dist_cm(input logic [GATE_W-1:0] g);
    gate_dist_cm = 16'(g * GATE_CM);
  endfunction : gate_dist_cm

  // any settings address other than control and status
  assign cfg_sel = (addr == ADDR_MAX_MOVE) || (addr == ADDR_MAX_STILL) || (addr == ADDR_HOLD)
                || (addr == ADDR_PW_LO) || (addr == ADDR_PW_HI)
                || is_thr(addr, ADDR_THR_MOVE) || is_thr(addr, ADDR_THR_STILL);
  assign cfg_wr     = wr && cfg_sel && !st.report_en;
  assign factory_wr = wr && (addr == ADDR_CTRL) && wdata[CTRL_FACTORY] && !st.report_en;

  always_ff @(posedge clk)
  begin
    if (factory_wr)
    begin
      max_move  <= DEF_MAX_GATE;
      max_still <= DEF_MAX_GATE;
      hold_sec  <= DEF_HOLD;
      password  <= DEF_PW;
      for (int g = 0; g < GATE_CNT; g++)
      begin
        thr_move[g]  <= DEF_THR;
        thr_still[g] <= DEF_THR;
      end
    end
    else if (cfg_wr)
    begin
      if (addr == ADDR_MAX_MOVE)
        max_move <= clamp_gate(wdata);
      if (addr == ADDR_MAX_STILL)
        max_still <= clamp_gate(wdata);
      if (addr == ADDR_HOLD)
        hold_sec <= wdata[15:0];
      if (addr == ADDR_PW_LO)
        password[31:0] <= wdata;
      if (addr == ADDR_PW_HI)
        password[47:32] <= wdata[15:0];
      if (is_thr(addr, ADDR_THR_MOVE))
        thr_move[thr_index(addr, ADDR_THR_MOVE)] <= clamp_thr(wdata);
      if (is_thr(addr, ADDR_THR_STILL))
        thr_still[thr_index(addr, ADDR_THR_STILL)] <= clamp_thr(wdata);
    end
  end

  // ***********************************************************
  // per-gate decision
  // ***********************************************************
  // strict compare: a threshold of 100 is beaten only by energy above 100
  assign move_det  = sample_valid && (sample_gate < GATE_W'(GATE_CNT))
                  && (sample_gate <= max_move)
                  && (move_energy > thr_move[sample_gate]);
  assign still_det = sample_valid && (sample_gate < GATE_W'(GATE_CNT))
                  && (sample_gate <= max_still)
                  && (still_energy > thr_still[sample_gate]);

  assign sec_tick = (st.sec_cnt == 32'(SEC_DIV - 1));

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb
  begin
    next_st       = st;
    next_st.rdata = '0;

    // control writes stay open so the host can stop reporting
    if (wr && addr == ADDR_CTRL)
      next_st.report_en = wdata[CTRL_REPORT];
    if ((wr || rd) && cfg_sel && st.report_en)
      next_st.refused = 1'b1;

    if (rd)
    begin
      if (addr == ADDR_CTRL)
        next_st.rdata = DATA_W'(st.report_en);
      else if (addr == ADDR_STATUS)
      begin
        next_st.rdata   = {27'h0, st.refused, st.report_en, st.raw_still, st.raw_move, st.presence};
        next_st.refused = (wr || rd) && cfg_sel && st.report_en;
      end
      else if (!st.report_en)
      begin
        if (addr == ADDR_MAX_MOVE)
          next_st.rdata = DATA_W'(max_move);
        else if (addr == ADDR_MAX_STILL)
          next_st.rdata = DATA_W'(max_still);
        else if (addr == ADDR_HOLD)
          next_st.rdata = DATA_W'(hold_sec);
        else if (addr == ADDR_PW_LO)
          next_st.rdata = password[31:0];
        else if (addr == ADDR_PW_HI)
          next_st.rdata = DATA_W'(password[47:32]);
        else if (is_thr(addr, ADDR_THR_MOVE))
          next_st.rdata = DATA_W'(thr_move[thr_index(addr, ADDR_THR_MOVE)]);
        else if (is_thr(addr, ADDR_THR_STILL))
          next_st.rdata = DATA_W'(thr_still[thr_index(addr, ADDR_THR_STILL)]);
      end
    end

    // nearest hit in the frame is kept
    if (move_det && !st.scan_move_hit)
    begin
      next_st.scan_move_hit  = 1'b1;
      next_st.scan_move_gate = sample_gate;
      next_st.scan_move_e    = move_energy;
    end
    if (still_det && !st.scan_still_hit)
    begin
      next_st.scan_still_hit  = 1'b1;
      next_st.scan_still_gate = sample_gate;
      next_st.scan_still_e    = still_energy;
    end

    next_st.sec_cnt = sec_tick ? 32'h0 : st.sec_cnt + 32'h1;

    if (sec_tick && st.presence && !(st.raw_move || st.raw_still))
    begin
      if (st.hold_cnt == 16'h0)
        next_st.presence = 1'b0;
      else
        next_st.hold_cnt = st.hold_cnt - 16'h1;
    end

    if (frame_end)
    begin
      next_st.raw_move        = st.scan_move_hit;
      next_st.raw_still       = st.scan_still_hit;
      next_st.rep_move_gate   = st.scan_move_hit ? st.scan_move_gate : '0;
      next_st.rep_move_e      = st.scan_move_hit ? st.scan_move_e : '0;
      next_st.rep_still_gate  = st.scan_still_hit ? st.scan_still_gate : '0;
      next_st.rep_still_e     = st.scan_still_hit ? st.scan_still_e : '0;
      next_st.scan_move_hit   = 1'b0;
      next_st.scan_still_hit  = 1'b0;
      if (st.scan_move_hit || st.scan_still_hit)
      begin
        next_st.presence = 1'b1;
        next_st.hold_cnt = hold_sec;
      end
      // a frame ending mid-report is not reported; snapshot still updates
      if (st.report_en && st.rep_state == REP_IDLE)
      begin
        next_st.rep_state = REP_SEND;
        next_st.rep_idx   = 4'h0;
      end
    end

    case (st.rep_state)
      REP_IDLE:
      begin
      end
      REP_SEND:
      begin
        if (rep_in.ready)
        begin
          if (st.rep_idx == REP_LAST)
            next_st.rep_state = REP_IDLE;
          else
            next_st.rep_idx = st.rep_idx + 4'h1;
        end
      end
      default:
      begin
        next_st.rep_state = REP_IDLE;
      end
    endcase
  end

  // ***********************************************************
  // report byte source
  // ***********************************************************
  assign move_dist  = gate_dist_cm(st.rep_move_gate);
  assign still_dist = gate_dist_cm(st.rep_still_gate);

  always_comb
  begin
    rep_in.valid = (st.rep_state == REP_SEND);
    case (st.rep_idx)
      4'h0:    rep_in.data = REP_HEAD;
      4'h1:    rep_in.data = {6'h00, st.raw_still, st.raw_move};
      4'h2:    rep_in.data = move_dist[7:0];
      4'h3:    rep_in.data = move_dist[15:8];
      4'h4:    rep_in.data = st.rep_move_e;
      4'h5:    rep_in.data = still_dist[7:0];
      4'h6:    rep_in.data = still_dist[15:8];
      4'h7:    rep_in.data = st.rep_still_e;
      default: rep_in.data = REP_TAIL;
    endcase
  end

  report_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk (clk),
    .rst (rst),
    .wr  (rep_in),
    .rd  (rep_out)
  );

  serial_sender #(
    .DIV (BAUD_DIV)
  ) u_tx (
    .clk (clk),
    .rst (rst),
    .in  (rep_out),
    .tx  (serial_tx)
  );

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st           <= '0;
      st.rep_state <= REP_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata        = st.rdata;
  assign presence_out = st.presence;

endmodule : presence_decision

// ===== bench/presence_decision_sva.sv
// Purpose: port-level checks of the presence decision block
// Assumes: single clock, asynchronous active-high reset, factory load before first read
// Notes:   report enable is mirrored from control writes, which are never refused
`timescale 1ns/1ps
module presence_decision_sva
  import presence_pkg::*;
#(
  parameter int SEC_DIV = presence_pkg::SEC_CYCLES
) (
  input wire logic                              clk,
  input wire logic                              rst,
  input wire logic [presence_pkg::ADDR_W-1:0]   addr,
  input wire logic [presence_pkg::DATA_W-1:0]   wdata,
  input wire logic                              wr,
  input wire logic                              rd,
  input wire logic [presence_pkg::DATA_W-1:0]   rdata,
  input wire logic                              sample_valid,
  input wire logic [presence_pkg::GATE_W-1:0]   sample_gate,
  input wire logic [presence_pkg::ENERGY_W-1:0] move_energy,
  input wire logic [presence_pkg::ENERGY_W-1:0] still_energy,
  input wire logic                              frame_end,
  input wire logic                              presence_out,
  input wire logic                              serial_tx
);
  logic        rep_en_h;
  logic        ever_en;
  logic [15:0] low_cnt;

  // ***********************************************************
  // helper state
  // ***********************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rep_en_h <= 1'b0;
      ever_en  <= 1'b0;
      low_cnt  <= '0;
    end
    else
    begin
      if (wr && addr == ADDR_CTRL)
      begin
        rep_en_h <= wdata[CTRL_REPORT];
        ever_en  <= ever_en | wdata[CTRL_REPORT];
      end
      // low runs start and end on bit edges, idle runs do not
      low_cnt <= serial_tx ? 16'h0000 : low_cnt + 16'h0001;
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RDATA_IDLE: assert property (!rd |=> rdata == '0)
    else $error("read data not zero outside a read answer");
  AST_PRES_RISE: assert property ($rose(presence_out) |-> $past(frame_end))
    else $error("presence rose without a closing frame");
  AST_STATUS_PIN: assert property (rd && addr == ADDR_STATUS |=>
    rdata[0] == $past(presence_out) && rdata[3] == $past(rep_en_h))
    else $error("status disagrees with pin or report enable");
  AST_CTRL_BACK: assert property (rd && addr == ADDR_CTRL |=> rdata[0] == $past(rep_en_h))
    else $error("control readback wrong");
  AST_LOCK_READ: assert property (rd && rep_en_h && addr != ADDR_CTRL && addr != ADDR_STATUS |=> rdata == '0)
    else $error("settings readable while reporting");
  AST_GATE_RANGE: assert property (rd && !rep_en_h && (addr == ADDR_MAX_MOVE || addr == ADDR_MAX_STILL) |=>
    rdata inside {[32'h1:32'h8]})
    else $error("max gate outside 1..8");
  AST_THR_RANGE: assert property (rd && !rep_en_h && addr >= ADDR_THR_MOVE && addr <= 8'ha0 |=>
    rdata <= 32'(THR_MAX))
    else $error("threshold above 100");
  AST_TX_QUIET: assert property (!ever_en |-> serial_tx)
    else $error("serial line active with reporting never enabled");
  AST_START_BIT: assert property ($fell(serial_tx) |-> !serial_tx [*8])
    else $error("start bit too short");
  AST_BIT_TIME: assert property ($rose(serial_tx) |->
    (low_cnt % BAUD_DIV == 0) && (low_cnt <= 9 * BAUD_DIV))
    else $error("low run not whole bit times");
endmodule : presence_decision_sva

bind presence_decision presence_decision_sva #(.SEC_DIV(SEC_DIV)) i_sva (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sample_valid(sample_valid), .sample_gate(sample_gate),
  .move_energy(move_energy), .still_energy(still_energy), .frame_end(frame_end), .presence_out(presence_out),
  .serial_tx(serial_tx));

// ===== bench/host_serial_rx.sv
// Purpose: host side serial receiver collecting report bytes
// Assumes: 8 data bits, lsb first, one stop bit, no parity
// Notes:   samples mid-bit; a low stop bit counts as a framing error
`timescale 1ns/1ps
module host_serial_rx
  import presence_pkg::*;
#(
  parameter int DIV = presence_pkg::BAUD_DIV
) (
  input wire logic clk,
  input wire logic rx
);
  logic [7:0] rx_q[$];
  int         framing_errors;
  logic [7:0] b;

  initial
  begin
    framing_errors = 0;
    forever
    begin
      @(negedge rx);
      repeat (DIV / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (DIV) @(posedge clk);
        b[i] = rx;
      end
      repeat (DIV) @(posedge clk);
      if (rx !== 1'b1)
        framing_errors++;
      rx_q.push_back(b);
    end
  end
endmodule : host_serial_rx

// ===== bench/tb.sv
// Purpose: self-checking bench for the presence decision block
// Assumes: second tick shortened to 100 cycles
// Notes:   settings loaded by factory command right after reset
`timescale 1ns/1ps
module tb;
  import presence_pkg::*;
  localparam int SEC = 100;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        sample_valid;
  logic [3:0]  sample_gate;
  logic [7:0]  move_energy;
  logic [7:0]  still_energy;
  logic        frame_end;
  logic        presence_out;
  logic        serial_tx;
  int          errors;
  int          check_count;
  int          cycles;
  int          n;
  logic [31:0] d;
  logic [7:0]  exp_b[9];

  presence_decision #(.SEC_DIV(SEC)) i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sample_valid(sample_valid), .sample_gate(sample_gate), .move_energy(move_energy),
    .still_energy(still_energy), .frame_end(frame_end), .presence_out(presence_out), .serial_tx(serial_tx));
  host_serial_rx #(.DIV(BAUD_DIV)) i_host (.clk(clk), .rx(serial_tx));

  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_read

  task automatic wr_rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] exp);
    reg_write(a, v);
    reg_read(a, d);
    check(d, exp);
  endtask : wr_rd

  task automatic sample(input logic [3:0] g, input logic [7:0] me, input logic [7:0] se);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_gate  <= g;
    move_energy  <= me;
    still_energy <= se;
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask : sample

  task automatic frame();
    @(posedge clk);
    frame_end <= 1'b1;
    @(posedge clk);
    frame_end <= 1'b0;
    @(posedge clk);
    #1;
  endtask : frame

  // empty frame clears the raw hit, hold 0 drops within one tick
  task automatic wait_clear();
    frame();
    for (n = 0; n < 4 * SEC && presence_out !== 1'b0; n++)
      @(posedge clk);
    check(32'(presence_out), 32'h0);
  endtask : wait_clear

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      errors++;
      print_verdict();
    end
  end

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial
  begin
    rst = 1'b1; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0; frame_end = 1'b0;
    sample_valid = 1'b0; sample_gate = 4'h0; move_energy = 8'h00; still_energy = 8'h00;
    errors = 0; check_count = 0; cycles = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reg_write(ADDR_CTRL, 32'h2);
    reg_read(ADDR_MAX_MOVE, d); check(d, 32'(DEF_MAX_GATE));
    reg_read(ADDR_MAX_STILL, d); check(d, 32'(DEF_MAX_GATE));
    reg_read(ADDR_HOLD, d); check(d, 32'(DEF_HOLD));
    reg_read(ADDR_PW_LO, d); check(d, DEF_PW[31:0]);
    reg_read(ADDR_PW_HI, d); check(d, {16'h0, DEF_PW[47:32]});
    reg_read(ADDR_STATUS, d); check(d, 32'h0);
    for (int g = 0; g < GATE_CNT; g++)
    begin
      reg_read(8'(ADDR_THR_MOVE + 4 * g), d); check(d, 32'(DEF_THR));
      reg_read(8'(ADDR_THR_STILL + 4 * g), d); check(d, 32'(DEF_THR));
    end
    wr_rd(ADDR_MAX_MOVE, 32'h0, 32'h1);
    wr_rd(ADDR_MAX_MOVE, 32'h9, 32'h8);
    wr_rd(8'(ADDR_THR_STILL + 32), 32'hff, 32'(THR_MAX));
    wr_rd(ADDR_PW_LO, 32'h61626364, 32'h61626364);
    wr_rd(8'h30, 32'hffff, 32'h0);
    // strict compare on the threshold of 40
    reg_write(ADDR_HOLD, 32'h0);
    sample(4'h2, 8'd40, 8'd0); frame(); check(32'(presence_out), 32'h0);
    sample(4'h2, 8'd41, 8'd0); frame(); check(32'(presence_out), 32'h1);
    reg_read(ADDR_STATUS, d); check(32'(d[2:0]), 32'h3);
    wait_clear();
    // hit mid-hold restarts the count: drop lands 2..3 ticks after the last hit
    reg_write(ADDR_HOLD, 32'h2);
    sample(4'h2, 8'd50, 8'd0); frame(); frame();
    repeat (150) @(posedge clk);
    check(32'(presence_out), 32'h1);
    sample(4'h2, 8'd50, 8'd0); frame(); frame();
    for (n = 0; n < 5 * SEC && presence_out === 1'b1; n++)
      @(posedge clk);
    check(32'(n >= 2 * SEC - 10 && n <= 3 * SEC + 5), 32'h1);
    reg_write(ADDR_HOLD, 32'h0);
    reg_write(ADDR_MAX_MOVE, 32'h2);
    reg_write(ADDR_MAX_STILL, 32'h2);
    wait_clear();
    sample(4'h3, 8'd90, 8'd90); frame(); check(32'(presence_out), 32'h0);
    sample(4'h2, 8'd0, 8'd90); frame(); check(32'(presence_out), 32'h1);
    reg_write(ADDR_MAX_MOVE, 32'h8);
    reg_write(8'(ADDR_THR_MOVE + 20), 32'd100);
    wait_clear();
    sample(4'h5, 8'd100, 8'd0); frame(); check(32'(presence_out), 32'h0);
    // report on: settings locked, one frame goes out
    reg_write(ADDR_CTRL, 32'h1);
    reg_read(ADDR_MAX_MOVE, d); check(d, 32'h0);
    reg_write(ADDR_MAX_MOVE, 32'h3);
    reg_read(ADDR_STATUS, d); check(32'(d[4:3]), 32'h3);
    reg_read(ADDR_CTRL, d); check(32'(d[0]), 32'h1);
    sample(4'h2, 8'd50, 8'd0); frame();
    for (n = 0; n < 40000 && i_host.rx_q.size() < 9; n++)
      @(posedge clk);
    check(32'(i_host.rx_q.size()), 32'd9);
    exp_b = '{REP_HEAD, 8'h01, 8'h96, 8'h00, 8'h32, 8'h00, 8'h00, 8'h00, REP_TAIL};
    for (int i = 0; i < 9; i++)
      check(32'(i_host.rx_q[i]), 32'(exp_b[i]));
    check(32'(i_host.rx_q[8]), 32'(REP_TAIL));
    check(32'(i_host.framing_errors), 32'h0);
    reg_write(ADDR_CTRL, 32'h0);
    reg_read(ADDR_MAX_MOVE, d); check(d, 32'h8);
    print_verdict();
  end
endmodule : tb
